/* design/burst_sram_pkg.sv */
// Shared constants and carrier types for the flow-through burst SRAM port.
// Assumes one rising-edge clock and an AXI4-Lite master for the control registers.
package burst_sram_pkg;

  // Array shape
  localparam int WORD_W = 18; // Data word width
  localparam int LANE_W = 9; // Bits per byte lane
  localparam int LANES = 2; // Byte lanes per word
  localparam int ADDR_W_DEF = 20; // Word address width
  localparam int BURST_W = 2; // Burst counter width

  // Register bus shape
  localparam int AXI_AW = 8; // Byte address width of the register window
  localparam int AXI_DW = 32; // Register data width

  // Register byte offsets
  localparam logic [AXI_AW-1:0] CTRL_OFS = 8'h00; // Port control
  localparam logic [AXI_AW-1:0] STATUS_OFS = 8'h04; // Port state
  localparam logic [AXI_AW-1:0] ADDR_OFS = 8'h08; // Current burst address
  localparam logic [AXI_AW-1:0] WDATA_OFS = 8'h0C; // Last captured write word
  localparam logic [AXI_AW-1:0] WCOUNT_OFS = 8'h10; // Written word counter

  // Field positions and reset values
  localparam int CTRL_EN_BIT = 0; // Port enable bit in control
  localparam logic CTRL_EN_RST = 1'b1; // Port enabled after reset
  localparam logic [1:0] RESP_OKAY = 2'h0; // AXI okay
  localparam logic [1:0] RESP_SLVERR = 2'h2; // AXI slave error

  // Access state of the port
  typedef enum logic [1:0] {
    ACC_IDLE = 2'b00,
    ACC_READ = 2'b01,
    ACC_WRITE = 2'b10
  } access_t;

  // Master to slave signals
  typedef struct packed {
    logic awvalid;
    logic [AXI_AW-1:0] awaddr;
    logic wvalid;
    logic [AXI_DW-1:0] wdata;
    logic [AXI_DW/8-1:0] wstrb;
    logic bready;
    logic arvalid;
    logic [AXI_AW-1:0] araddr;
    logic rready;
  } axil_req_t;

  // Slave to master signals
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [AXI_DW-1:0] rdata;
    logic [1:0] rresp;
  } axil_resp_t;

endpackage

/* design/flowthrough_burst_sram_port.sv */
// Flow-through burst SRAM port: strobe decode, burst counter, byte-lane array and control registers.
// Assumes all pins synchronous to aclk except output_enable_n and snooze_request, which act directly.
// Operation
// R1 - Processor strobe with enables loads address, reads
// R2 - Read data flows straight from registered address
// R3 - Burst step ignored on processor strobe edge
// R4 - Step burst when step low, strobes high
// R5 - Order select high interleaved, low linear
// R6 - Master disables outputs before issuing writes
// R7 - Global write writes all eighteen bits
// R8 - Otherwise write only enabled byte lanes
// R9 - Lane writes ignored on processor strobe edge
// R10 - Sampled lane write disables output buffers
// R11 - Lane write captures data input register
// R12 - Write burst steps with lane write, step
// R13 - Controller start needs processor strobe high
// R14 - Controller start samples write controls immediately
// R15 - Output enable acts without the clock
// R16 - Load address only with all enables active
// R17 - Second enable high-active, third low-active
// R18 - No lane write selected means read
// R19 - Snooze ignores inputs, floats data outputs
// R20 - Burst touches two low bits, wraps four
// R21 - Master enable blocks only processor strobe
`timescale 1ns/1ps
module flowthrough_burst_sram_port import burst_sram_pkg::*; #(
  parameter int ADDR_W = ADDR_W_DEF
) (
  // Clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  // Register bus
  input wire axil_req_t axil_req,
  output axil_resp_t axil_resp,
  // Address and strobes
  input wire logic [ADDR_W-1:0] addr,
  input wire logic processor_addr_strobe_n,
  input wire logic controller_addr_strobe_n,
  input wire logic burst_step_n,
  input wire logic burst_order_select,
  // Chip selects
  input wire logic master_chip_select_n,
  input wire logic second_chip_select,
  input wire logic third_chip_select_n,
  // Write controls
  input wire logic global_write_en_n,
  input wire logic byte_write_en_n,
  input wire logic [LANES-1:0] byte_lane_write_n,
  // Asynchronous controls
  input wire logic output_enable_n,
  input wire logic snooze_request,
  // Data pins, split into three signals
  input wire logic [WORD_W-1:0] dq_in,
  output logic [WORD_W-1:0] dq_out,
  output logic dq_oe
);

  ////////////////////////////////////////////////////////////////////////////
  // Storage and port state

  logic [WORD_W-1:0] mem [2**ADDR_W]; // Array, deliberately not reset
  access_t acc_reg, acc_next; // Current access kind
  logic [ADDR_W-1:0] base_reg, base_next; // Address loaded by a strobe
  logic [BURST_W-1:0] cnt_reg, cnt_next; // Burst step count
  logic [WORD_W-1:0] din_reg, din_next; // Data input register
  logic [15:0] wcount_reg, wcount_next; // Words written
  logic ctrl_en_reg, ctrl_en_next; // Software port enable
  logic [LANES-1:0] lane_we; // Lanes written this edge
  logic [ADDR_W-1:0] wr_addr; // Address written this edge
  logic [BURST_W-1:0] low_bits; // Burst-ordered low address bits
  logic [ADDR_W-1:0] cur_addr; // Address of the current word
  logic enables_ok; // All three chip selects active and port enabled
  logic psel_take; // Processor strobe not blocked
  logic [LANES-1:0] wr_lanes; // Lanes requested by write pins
  logic wr_any; // Any lane requested

  ////////////////////////////////////////////////////////////////////////////
  // Address and write decode

  // Burst order only touches the two low bits, upper bits stay as loaded
  always_comb begin
    if (burst_order_select) begin
      low_bits = base_reg[BURST_W-1:0] ^ cnt_reg; // [R5] [R20]
    end else begin
      low_bits = base_reg[BURST_W-1:0] + cnt_reg; // [R5] [R20]
    end
    cur_addr = {base_reg[ADDR_W-1:BURST_W], low_bits};
  end

  // Chip selects and strobe qualification
  always_comb begin
    enables_ok = ctrl_en_reg && !master_chip_select_n && second_chip_select && !third_chip_select_n; // [R17]
    psel_take = !processor_addr_strobe_n && !master_chip_select_n; // [R21]
    if (!global_write_en_n) begin
      wr_lanes = {LANES{1'b1}}; // [R7]
    end else if (!byte_write_en_n) begin
      wr_lanes = ~byte_lane_write_n; // [R8]
    end else begin
      wr_lanes = '0; // [R8]
    end
    wr_any = |wr_lanes; // [R18]
  end

  ////////////////////////////////////////////////////////////////////////////
  // Port sequencing: next values

  always_comb begin
    acc_next = acc_reg;
    base_next = base_reg;
    cnt_next = cnt_reg;
    din_next = din_reg;
    wcount_next = wcount_reg;
    lane_we = '0;
    wr_addr = cur_addr;
    if (snooze_request) begin
      // Asleep: every pin but snooze is ignored
      acc_next = acc_reg; // [R19]
    end else if (psel_take) begin
      // Processor start is a read with all enables, else idle; step and lane pins ignored
      if (enables_ok) begin
        base_next = addr; // [R1] [R16]
        cnt_next = '0; // [R3] [R9]
        acc_next = ACC_READ; // [R1]
      end else begin
        acc_next = ACC_IDLE; // [R16]
      end
    end else if (!controller_addr_strobe_n) begin
      // Controller start may be a write at once
      if (enables_ok) begin
        base_next = addr; // [R16]
        cnt_next = '0;
        if (wr_any) begin
          acc_next = ACC_WRITE; // [R14]
          lane_we = wr_lanes; // [R14]
          wr_addr = addr;
          din_next = dq_in; // [R11]
          wcount_next = wcount_reg + 16'h0001;
        end else begin
          acc_next = ACC_READ; // [R14] [R18]
        end
      end else begin
        acc_next = ACC_IDLE; // [R16]
      end
    end else if (acc_reg != ACC_IDLE) begin
      // Burst continuation, controller strobe inactive, processor strobe inactive or blocked
      if (wr_any) begin
        acc_next = ACC_WRITE; // [R9]
        lane_we = wr_lanes; // [R7] [R8]
        din_next = dq_in; // [R11]
        wcount_next = wcount_reg + 16'h0001;
      end else begin
        acc_next = ACC_READ; // [R18]
      end
      if (!burst_step_n) begin
        cnt_next = cnt_reg + 2'h1; // [R4] [R12] [R20]
      end
    end
  end

  // Port sequencing: registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc_reg <= ACC_IDLE;
      base_reg <= '0;
      cnt_reg <= '0;
      din_reg <= '0;
      wcount_reg <= 16'h0000;
    end else if (clk_en) begin
      acc_reg <= acc_next;
      base_reg <= base_next;
      cnt_reg <= cnt_next;
      din_reg <= din_next;
      wcount_reg <= wcount_next;
    end
  end

  // Array write per lane; lanes held in a loop to avoid repetition
  always_ff @(posedge aclk) begin
    if (clk_en && aresetn) begin
      for (int i = 0; i < LANES; i++) begin
        if (lane_we[i]) begin
          mem[wr_addr][i*LANE_W +: LANE_W] <= dq_in[i*LANE_W +: LANE_W]; // [R7] [R8]
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data pins: flow-through, so these bypass flops on purpose

  // A write access keeps drivers off even if the master forgets
  always_comb begin
    dq_out = mem[cur_addr]; // [R2]
    dq_oe = !snooze_request && (acc_reg == ACC_READ) && !output_enable_n; // [R10] [R15] [R19] [R6]
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register slave

  logic aw_have_reg, aw_have_next; // Write address held
  logic [AXI_AW-1:0] aw_addr_reg, aw_addr_next;
  logic w_have_reg, w_have_next; // Write data held
  logic [AXI_DW-1:0] w_data_reg, w_data_next;
  logic [AXI_DW/8-1:0] w_strb_reg, w_strb_next;
  logic awready_reg, awready_next;
  logic wready_reg, wready_next;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic arready_reg, arready_next;
  logic rvalid_reg, rvalid_next;
  logic [AXI_DW-1:0] rdata_reg, rdata_next;
  logic [1:0] rresp_reg, rresp_next;

  // Bus next values; address and data may arrive in either order
  always_comb begin
    aw_have_next = aw_have_reg;
    aw_addr_next = aw_addr_reg;
    w_have_next = w_have_reg;
    w_data_next = w_data_reg;
    w_strb_next = w_strb_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    ctrl_en_next = ctrl_en_reg;
    arready_next = arready_reg;
    // Capture halves of a write
    if (axil_req.awvalid && awready_reg) begin
      aw_have_next = 1'b1;
      aw_addr_next = axil_req.awaddr;
    end
    if (axil_req.wvalid && wready_reg) begin
      w_have_next = 1'b1;
      w_data_next = axil_req.wdata;
      w_strb_next = axil_req.wstrb;
    end
    // Perform the write once both halves are in
    if (aw_have_reg && w_have_reg && !bvalid_reg) begin
      aw_have_next = 1'b0;
      w_have_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = RESP_OKAY;
      if (aw_addr_reg[AXI_AW-1:2] == CTRL_OFS[AXI_AW-1:2]) begin
        if (w_strb_reg[0]) begin
          ctrl_en_next = w_data_reg[CTRL_EN_BIT];
        end
      end else if (aw_addr_reg[AXI_AW-1:2] == STATUS_OFS[AXI_AW-1:2] ||
                   aw_addr_reg[AXI_AW-1:2] == ADDR_OFS[AXI_AW-1:2] ||
                   aw_addr_reg[AXI_AW-1:2] == WDATA_OFS[AXI_AW-1:2] ||
                   aw_addr_reg[AXI_AW-1:2] == WCOUNT_OFS[AXI_AW-1:2]) begin
        bresp_next = RESP_OKAY; // Read-only, write dropped
      end else begin
        bresp_next = RESP_SLVERR; // Unmapped
      end
    end else if (bvalid_reg && axil_req.bready) begin
      bvalid_next = 1'b0;
    end
    // Read: answer one cycle after the address is taken
    if (axil_req.arvalid && arready_reg) begin
      arready_next = 1'b0;
      rvalid_next = 1'b1;
      rresp_next = RESP_OKAY;
      rdata_next = '0;
      unique case (axil_req.araddr[AXI_AW-1:2])
        CTRL_OFS[AXI_AW-1:2]: rdata_next[CTRL_EN_BIT] = ctrl_en_reg;
        STATUS_OFS[AXI_AW-1:2]: rdata_next[4:0] = {cnt_reg, snooze_request, acc_reg};
        ADDR_OFS[AXI_AW-1:2]: rdata_next[ADDR_W-1:0] = cur_addr;
        WDATA_OFS[AXI_AW-1:2]: rdata_next[WORD_W-1:0] = din_reg;
        WCOUNT_OFS[AXI_AW-1:2]: rdata_next[15:0] = wcount_reg;
        default: rresp_next = RESP_SLVERR;
      endcase
    end else if (rvalid_reg && axil_req.rready) begin
      rvalid_next = 1'b0;
      arready_next = 1'b1;
    end
    // Hold off new write halves while one is pending
    awready_next = !aw_have_next && !bvalid_next;
    wready_next = !w_have_next && !bvalid_next;
  end

  // Bus registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_have_reg <= 1'b0;
      w_data_reg <= '0;
      w_strb_reg <= '0;
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= RESP_OKAY;
      ctrl_en_reg <= CTRL_EN_RST;
    end else if (clk_en) begin
      aw_have_reg <= aw_have_next;
      aw_addr_reg <= aw_addr_next;
      w_have_reg <= w_have_next;
      w_data_reg <= w_data_next;
      w_strb_reg <= w_strb_next;
      awready_reg <= awready_next;
      wready_reg <= wready_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      arready_reg <= (arready_reg || rvalid_reg) ? arready_next : 1'b1;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
      ctrl_en_reg <= ctrl_en_next;
    end
  end

  // Response bundle, all from flops
  always_comb begin
    axil_resp.awready = awready_reg;
    axil_resp.wready = wready_reg;
    axil_resp.bvalid = bvalid_reg;
    axil_resp.bresp = bresp_reg;
    axil_resp.arready = arready_reg;
    axil_resp.rvalid = rvalid_reg;
    axil_resp.rdata = rdata_reg;
    axil_resp.rresp = rresp_reg;
  end

endmodule

/* test/port_checker_properties.sv */
// Concurrent checks on the burst SRAM port pins and its register bus.
// Assumes the control enable bit stays set and clk_en stays high.
`timescale 1ns/1ps
module port_checker import burst_sram_pkg::*; #(
  parameter int ADDR_W = ADDR_W_DEF
) (
  // Clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  // Register bus
  input wire axil_req_t axil_req,
  input wire axil_resp_t axil_resp,
  // Strobes and selects
  input wire logic [ADDR_W-1:0] addr,
  input wire logic processor_addr_strobe_n,
  input wire logic controller_addr_strobe_n,
  input wire logic master_chip_select_n,
  input wire logic second_chip_select,
  input wire logic third_chip_select_n,
  // Write and asynchronous controls
  input wire logic global_write_en_n,
  input wire logic byte_write_en_n,
  input wire logic [LANES-1:0] byte_lane_write_n,
  input wire logic output_enable_n,
  input wire logic snooze_request,
  // Data pins
  input wire logic [WORD_W-1:0] dq_in,
  input wire logic [WORD_W-1:0] dq_out,
  input wire logic dq_oe
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////
  // Decoded edges; snooze edges count for nothing
  wire logic live = clk_en && !snooze_request;
  wire logic sel_ok = !master_chip_select_n && second_chip_select && !third_chip_select_n;
  wire logic p_go = live && !processor_addr_strobe_n && !master_chip_select_n;
  wire logic c_go = live && !controller_addr_strobe_n && processor_addr_strobe_n;
  wire logic wr_cmd = !global_write_en_n || (!byte_write_en_n && byte_lane_write_n != 2'b11);
  ////////////////////////////////////////////////////////////
  AST_PROC_READ_DRIVES: assert property (p_go && sel_ok |=> output_enable_n || dq_oe)
    else $error("processor start did not drive data");
  AST_PROC_LANES_IGNORED: assert property (p_go && sel_ok ##1 p_go && sel_ok && addr == $past(addr)
    |=> dq_out == $past(dq_out)) else $error("start edge wrote the word");
  AST_WRITE_FLOATS: assert property (c_go && sel_ok && wr_cmd |=> !dq_oe)
    else $error("data driven after a write");
  AST_DESELECT_IDLE: assert property ((p_go || c_go) && !sel_ok |=> !dq_oe)
    else $error("start without all selects drove data");
  AST_GLOBAL_READBACK: assert property (c_go && sel_ok && !global_write_en_n
    ##1 p_go && sel_ok && addr == $past(addr) |=> dq_out == $past(dq_in, 2)) else $error("word read back wrong");
  AST_OE_GATES: assert property (output_enable_n |-> !dq_oe)
    else $error("data driven with output enable off");
  AST_SNOOZE_FLOATS: assert property (snooze_request |-> !dq_oe)
    else $error("data driven in snooze");
  AST_READ_ANSWER: assert property (axil_req.arvalid && axil_resp.arready |=> axil_resp.rvalid)
    else $error("read answer late");
  AST_WRITE_RESP_ENDS: assert property (axil_resp.bvalid && axil_req.bready |=> !axil_resp.bvalid)
    else $error("write response held after handshake");
endmodule
bind flowthrough_burst_sram_port port_checker #(.ADDR_W(ADDR_W)) i_port_checker (.*);

/* test/cache_ctrl_model.sv */
// Bus master model driving the SRAM pins one clock cycle per call.
// Assumes the bench calls cyc back to back and sets the select pins between calls.
`timescale 1ns/1ps
module cache_ctrl_model #(
  parameter int ADDR_W = 6
) (
  // Clock
  input wire logic aclk,
  // Address and strobes
  output logic [ADDR_W-1:0] addr,
  output logic processor_addr_strobe_n,
  output logic controller_addr_strobe_n,
  output logic burst_step_n,
  output logic burst_order_select,
  // Chip selects
  output logic master_chip_select_n,
  output logic second_chip_select,
  output logic third_chip_select_n,
  // Write controls
  output logic global_write_en_n,
  output logic byte_write_en_n,
  output logic [1:0] byte_lane_write_n,
  // Asynchronous controls
  output logic output_enable_n,
  output logic snooze_request,
  // Data toward the port
  output logic [17:0] dq_in
);
  // Idle bus at time zero, selects active
  initial begin
    {processor_addr_strobe_n, controller_addr_strobe_n, burst_step_n, burst_order_select} = 4'hF;
    {master_chip_select_n, second_chip_select, third_chip_select_n, snooze_request} = 4'h4;
    {global_write_en_n, byte_write_en_n, byte_lane_write_n, output_enable_n} = 5'h1F;
    addr = '0;
    dq_in = 18'h15555;
  end
  ////////////////////////////////////////////////////////////
  // One cycle, launched just after a rising edge
  task cyc(input logic ps_n, cs_n, adv_n, gw_n, bwe_n, input logic [1:0] bw_n,
           input logic [ADDR_W-1:0] a, input logic [17:0] d);
    logic wr;
    wr = ps_n && (!gw_n || (!bwe_n && bw_n != 2'b11));
    @(posedge aclk);
    output_enable_n <= wr; // Buffers off before any write
    processor_addr_strobe_n <= ps_n;
    controller_addr_strobe_n <= cs_n || !ps_n; // Controller start only with processor strobe high
    burst_step_n <= adv_n;
    global_write_en_n <= gw_n;
    byte_write_en_n <= bwe_n;
    byte_lane_write_n <= bw_n;
    addr <= a;
    dq_in <= wr ? d : ~dq_in; // Released pins never keep the last word
  endtask
endmodule

/* test/test_flowthrough_burst_sram_port.sv */
// Self-checking bench: register bus, burst orders, byte lanes, selects, snooze.
// Assumes the port and its checker compile beside the cache controller model.
`timescale 1ns/1ps
module test_flowthrough_burst_sram_port import burst_sram_pkg::*;;
  localparam int AW = 6; // Short address for simulation
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic clk_en = 1'b1; // Tied high: freezing is not exercised
  axil_req_t axil_req = '0;
  axil_resp_t axil_resp;
  logic [AW-1:0] addr;
  logic processor_addr_strobe_n, controller_addr_strobe_n, burst_step_n, burst_order_select;
  logic master_chip_select_n, second_chip_select, third_chip_select_n, snooze_request;
  logic global_write_en_n, byte_write_en_n, output_enable_n, dq_oe;
  logic [1:0] byte_lane_write_n;
  logic [WORD_W-1:0] dq_in, dq_out;
  int err_total = 0;
  int checked = 0;
  always #25 aclk = ~aclk; // 20 MHz
  flowthrough_burst_sram_port #(.ADDR_W(AW)) i_flowthrough_burst_sram_port (.*);
  cache_ctrl_model #(.ADDR_W(AW)) i_cache_ctrl_model (.*);
  ////////////////////////////////////////////////////////////
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  task end_sim;
    $display("Comparisons %0d, mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Register write; ready is judged at the falling edge before the taking edge
  task axw(input logic [AXI_AW-1:0] a, input logic [AXI_DW-1:0] d, input logic [1:0] r);
    logic [2:0] p;
    logic [2:0] t;
    p = 3'b111;
    @(posedge aclk);
    axil_req <= '{awvalid: 1'b1, awaddr: a, wvalid: 1'b1, wdata: d, wstrb: 4'hF, bready: 1'b1, default: '0};
    while (p != 3'b000) begin
      @(negedge aclk);
      t = p & {axil_resp.awready, axil_resp.wready, axil_resp.bvalid};
      if (t[0]) chk(32'(axil_resp.bresp), 32'(r));
      @(posedge aclk);
      p = p & ~t;
      axil_req.awvalid <= p[2];
      axil_req.wvalid <= p[1];
      axil_req.bready <= p[0];
    end
  endtask
  task axr(input logic [AXI_AW-1:0] a, input logic [AXI_DW-1:0] d, input logic [1:0] r);
    logic [1:0] p;
    logic [1:0] t;
    p = 2'b11;
    @(posedge aclk);
    axil_req <= '{arvalid: 1'b1, araddr: a, rready: 1'b1, default: '0};
    while (p != 2'b00) begin
      @(negedge aclk);
      t = p & {axil_resp.arready, axil_resp.rvalid};
      if (t[0]) chk(axil_resp.rdata, d);
      if (t[0]) chk(32'(axil_resp.rresp), 32'(r));
      @(posedge aclk);
      p = p & ~t;
      axil_req.arvalid <= p[1];
      axil_req.rready <= p[0];
    end
  endtask
  // SRAM cycles: global write start, processor start, continue, check
  task wr(input logic [AW-1:0] a, input logic [WORD_W-1:0] d);
    i_cache_ctrl_model.cyc(1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 2'b11, a, d);
  endtask
  task rs(input logic [AW-1:0] a);
    i_cache_ctrl_model.cyc(1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 2'b00, a, 18'h00000);
  endtask
  task nx(input logic adv_n);
    i_cache_ctrl_model.cyc(1'b1, 1'b1, adv_n, 1'b1, 1'b1, 2'b11, 6'h00, 18'h00000);
  endtask
  task see(input logic [WORD_W-1:0] e);
    @(negedge aclk);
    chk(32'(dq_out), 32'(e));
    chk(32'(dq_oe), 32'h1);
  endtask
  task rd1(input logic [AW-1:0] a, input logic [WORD_W-1:0] e);
    rs(a);
    nx(1'b1);
    see(e);
  endtask
  ////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axr(CTRL_OFS, 32'h00000001, RESP_OKAY);
    axw(CTRL_OFS, 32'h00000001, RESP_OKAY);
    axr(8'h40, 32'h00000000, RESP_SLVERR);
    $display("Register bus test done");
    for (int o = 0; o < 2; o++) begin
      i_cache_ctrl_model.burst_order_select <= o[0];
      for (int i = 3; i >= 0; i--) wr(6'h14 + 6'((i + 1) % 4), 18'h2A000 + 18'(o * 16 + (i + 1) % 4));
      rs(6'h15);
      rs(6'h15);
      for (int k = 0; k < 4; k++) begin
        nx(1'b0);
        see(18'h2A000 + 18'(o * 16 + (o ? (1 ^ k) : ((1 + k) % 4))));
      end
    end
    $display("Burst order test done");
    i_cache_ctrl_model.cyc(1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 2'b10, 6'h15, 18'h3FFFF);
    rd1(6'h15, 18'h2A1FF);
    i_cache_ctrl_model.cyc(1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 2'b01, 6'h15, 18'h00000);
    rd1(6'h15, 18'h001FF);
    for (int b = 0; b < 2; b++) begin
      i_cache_ctrl_model.cyc(1'b1, 1'b0, 1'b1, 1'b1, 1'(b), 2'(3 - 3 * b), 6'h15, 18'h00000);
      nx(1'b1);
      see(18'h001FF);
    end
    $display("Byte lane test done");
    i_cache_ctrl_model.third_chip_select_n <= 1'b1;
    wr(6'h15, 18'h00000);
    nx(1'b1);
    i_cache_ctrl_model.third_chip_select_n <= 1'b0;
    rd1(6'h15, 18'h001FF);
    i_cache_ctrl_model.master_chip_select_n <= 1'b1;
    // Blocked start is a plain continue, so no lane pins low here
    i_cache_ctrl_model.cyc(1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 2'b11, 6'h14, 18'h00000);
    nx(1'b1);
    i_cache_ctrl_model.master_chip_select_n <= 1'b0;
    see(18'h001FF);
    $display("Select test done");
    i_cache_ctrl_model.snooze_request <= 1'b1;
    wr(6'h15, 18'h00000);
    nx(1'b1);
    @(negedge aclk);
    chk(32'(dq_oe), 32'h0);
    nx(1'b1);
    i_cache_ctrl_model.snooze_request <= 1'b0;
    rd1(6'h15, 18'h001FF);
    $display("Snooze test done");
    end_sim;
  end
  // Watchdog, far beyond the fewer than a hundred cycles the tests need
  initial begin
    repeat (5000) @(posedge aclk);
    err_total++;
    end_sim;
  end
endmodule
